// ### rtl/bpwm_defines.vh
// Constants for the bridge PWM output steering block
`ifndef BPWM_DEFINES_VH
`define BPWM_DEFINES_VH

// Register byte offsets on the APB
`define BPWM_OFF_CTRL 8'h00
`define BPWM_OFF_DUTY 8'h04
`define BPWM_OFF_PERIOD 8'h08
`define BPWM_OFF_DEADBAND 8'h0C
`define BPWM_OFF_TIMEBASE 8'h10
`define BPWM_OFF_STATUS 8'h14

// Field positions in pwm_control_reg
`define BPWM_CTRL_MODE 3:0
`define BPWM_CTRL_POL_BD 0
`define BPWM_CTRL_POL_AC 1
`define BPWM_CTRL_PWM_ON 3:2
`define BPWM_CTRL_DUTY_LO 5:4
`define BPWM_CTRL_CFG 7:6
`define BPWM_CTRL_DIR 7
`define BPWM_CTRL_FULL 6

// Field positions in the timebase control and deadband registers
`define BPWM_TB_PRESCALE 1:0
`define BPWM_TB_RUN 2
`define BPWM_DB_COUNT 6:0

// Field positions in the status register
`define BPWM_ST_COUNT 7:0
`define BPWM_ST_QUARTER 9:8
`define BPWM_ST_PINS 13:10
`define BPWM_ST_DIR 14

// Reset values
`define BPWM_CTRL_RST 8'h00
`define BPWM_DUTY_RST 8'h00
`define BPWM_PERIOD_RST 8'hFF
`define BPWM_DB_RST 7'h00
`define BPWM_TB_RST 3'h0

// Output configuration codes
`define BPWM_CFG_SINGLE 2'h0
`define BPWM_CFG_FWD 2'h1
`define BPWM_CFG_HALF 2'h2
`define BPWM_CFG_REV 2'h3
`define BPWM_MODE_PWM 2'h3

// Prescale select codes and their last divider count (value minus one)
`define BPWM_PRE_SEL_1 2'h0
`define BPWM_PRE_SEL_4 2'h1
`define BPWM_PRE_LAST_1 4'h0
`define BPWM_PRE_LAST_4 4'h3
`define BPWM_PRE_LAST_16 4'hF

// One instruction cycle is four oscillator periods; one pclk is one Tosc
`define BPWM_TOSC_NS 4
`define BPWM_TCY_TOSC 4
`define BPWM_LAST_QUARTER 2'h3
`define BPWM_DB_CNT_MAX 9'h1FF

`endif

// ### rtl/bpwm_timebase.v
// Prescaled period timebase with quarter-step resolution for the PWM
`timescale 1ns/100ps
`include "bpwm_defines.vh"

module bpwm_timebase (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire run,
  input wire [1:0] prescale_sel,
  input wire [7:0] period,
  output reg [7:0] count,
  output reg [1:0] quarter,
  output wire wrap,
  output wire last_step
);

  reg [3:0] pre;
  reg [3:0] pre_last;

  // Prescale divider length: 1, 4 or 16 pclk per quarter step
  always @* begin
    if (prescale_sel == `BPWM_PRE_SEL_1)
      pre_last = `BPWM_PRE_LAST_1;
    else if (prescale_sel == `BPWM_PRE_SEL_4)
      pre_last = `BPWM_PRE_LAST_4;
    else
      pre_last = `BPWM_PRE_LAST_16;
  end

  wire tick = run && (pre == pre_last);

  // Period ends after the last quarter of the step where count equals period
  assign wrap = tick && (quarter == `BPWM_LAST_QUARTER) && (count == period);
  // Final instruction cycle of the period, prescaled
  assign last_step = (count == period);

  // Counter chain: prescaler, quarter step, timebase_counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 4'h0;
      quarter <= 2'h0;
      count <= 8'h00;
    end else if (ce && run) begin
      if (tick) begin
        pre <= 4'h0;
        quarter <= quarter + 2'h1;
        if (wrap)
          count <= 8'h00;
        else if (quarter == `BPWM_LAST_QUARTER)
          count <= count + 8'h01;
      end else begin
        pre <= pre + 4'h1;
      end
    end
  end

endmodule // bpwm_timebase

// ### rtl/bpwm_steer.v
// Bridge PWM output steering with dead-band and direction change, APB slave
//
// Behaviour
// - Four output configurations are selected by the two-bit output_config_field.
// - Codes: 00 single, 01 full forward, 10 half-bridge, 11 reverse; unused pins released.
// - Mode codes 1100..1111 set polarity for pair a/c and pair b/d separately.
// - Period is 4 Tosc times period_register plus one times the prescale.
// - Active time is Tosc times the 10-bit duty value times the prescale.
// - Dead-band delay is one instruction cycle times the seven-bit deadband_count.
// - Timebase prescale is 1, 4 or 16 from timebase_prescale_select.
// - Half-bridge drives the waveform on out_a and its complement on out_b.
// - Half-bridge delays each inactive-to-active change by the dead-band; never the reverse.
// - If the dead-band exceeds the active time the output stays inactive all cycle.
// - Forward holds out_a active, modulates out_d; reverse holds out_c, modulates out_b.
// - A new direction_select_bit takes effect from the next PWM cycle.
// - Pending reversal: modulated outputs off, unmodulated switched, one prescaled Tcy early.
// - Modulated outputs stay inactive from that switch until the next period starts.
// - Full-bridge modes insert no dead-band delay.
// - Without half-bridge support, dead-band and half-bridge operation are absent.
// - Controls load at period boundary; dead-band loads at duty or period boundary.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "bpwm_defines.vh"

module bpwm_steer #(
  parameter HALF_BRIDGE_PRESENT = 1
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg out_a,
  output reg out_b,
  output reg out_c,
  output reg out_d,
  output reg out_a_en,
  output reg out_b_en,
  output reg out_c_en,
  output reg out_d_en
);

  // Software-visible registers
  reg [7:0] pwm_control_reg;
  reg [7:0] duty_high_byte;
  reg [7:0] period_register;
  reg [6:0] deadband_delay_reg;
  reg [2:0] timebase_ctrl;

  // Double-buffered copies in use by the waveform logic
  reg [7:0] act_ctrl;
  reg [9:0] act_duty;
  reg [6:0] act_deadband;
  wire act_dir = act_ctrl[`BPWM_CTRL_DIR];

  wire [7:0] tb_count;
  wire [1:0] tb_quarter;
  wire tb_wrap;
  wire tb_last_step;
  wire tb_run = timebase_ctrl[`BPWM_TB_RUN];

  // Timebase: 4*(period+1)*prescale pclk per period
  bpwm_timebase u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(tb_run),
    .prescale_sel(timebase_ctrl[`BPWM_TB_PRESCALE]),
    .period(period_register),
    .count(tb_count),
    .quarter(tb_quarter),
    .wrap(tb_wrap),
    .last_step(tb_last_step)
  );

  // APB decode; one wait state so every answer comes from a flop
  wire apb_access = psel && penable;
  wire apb_done = apb_access && pready;
  wire apb_write = apb_done && pwrite;
  reg addr_ok;
  reg [31:0] read_mux;

  always @* begin
    addr_ok = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      `BPWM_OFF_CTRL: read_mux[7:0] = pwm_control_reg;
      `BPWM_OFF_DUTY: read_mux[7:0] = duty_high_byte;
      `BPWM_OFF_PERIOD: read_mux[7:0] = period_register;
      `BPWM_OFF_DEADBAND: read_mux[6:0] = deadband_delay_reg;
      `BPWM_OFF_TIMEBASE: read_mux[2:0] = timebase_ctrl;
      `BPWM_OFF_STATUS: begin
        read_mux[`BPWM_ST_COUNT] = tb_count;
        read_mux[`BPWM_ST_QUARTER] = tb_quarter;
        read_mux[`BPWM_ST_PINS] = {out_d, out_c, out_b, out_a};
        read_mux[`BPWM_ST_DIR] = act_dir;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (apb_access && !pready) begin
        pready <= 1'b1;
        pslverr <= !addr_ok;
        prdata <= (!pwrite && addr_ok) ? read_mux : 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Register writes; direction bit accepted at any phase of the timebase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_control_reg <= `BPWM_CTRL_RST;
      duty_high_byte <= `BPWM_DUTY_RST;
      period_register <= `BPWM_PERIOD_RST;
      deadband_delay_reg <= `BPWM_DB_RST;
      timebase_ctrl <= `BPWM_TB_RST;
    end else if (ce && apb_write) begin
      case (paddr)
        `BPWM_OFF_CTRL: pwm_control_reg <= pwdata[7:0];
        `BPWM_OFF_DUTY: duty_high_byte <= pwdata[7:0];
        `BPWM_OFF_PERIOD: period_register <= pwdata[7:0];
        `BPWM_OFF_DEADBAND: begin
          if (HALF_BRIDGE_PRESENT != 0)
            deadband_delay_reg <= pwdata[`BPWM_DB_COUNT];
        end
        `BPWM_OFF_TIMEBASE: timebase_ctrl <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Raw duty comparison on the quarter-resolution count
  wire [9:0] fine_count = {tb_count, tb_quarter};
  wire pwm_raw = tb_run && (fine_count < act_duty);
  reg pwm_raw_d;
  wire duty_edge = pwm_raw_d && !pwm_raw;

  // Shadow loads: controls and duty at the period boundary, or while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ctrl <= `BPWM_CTRL_RST;
      act_duty <= 10'h000;
      act_deadband <= `BPWM_DB_RST;
      pwm_raw_d <= 1'b0;
    end else if (ce) begin
      pwm_raw_d <= pwm_raw;
      if (tb_wrap || !tb_run) begin
        act_ctrl <= pwm_control_reg;
        act_duty <= {duty_high_byte, pwm_control_reg[`BPWM_CTRL_DUTY_LO]};
      end
      if (tb_wrap || duty_edge || !tb_run)
        act_deadband <= deadband_delay_reg;
    end
  end

  // Active configuration; half-bridge falls back to single when absent
  wire [1:0] cfg_raw = act_ctrl[`BPWM_CTRL_CFG];
  wire [1:0] act_cfg = (HALF_BRIDGE_PRESENT == 0 && cfg_raw == `BPWM_CFG_HALF) ?
                       `BPWM_CFG_SINGLE : cfg_raw;
  wire pwm_on = (act_ctrl[`BPWM_CTRL_PWM_ON] == `BPWM_MODE_PWM);
  wire act_full = act_cfg[0];
  wire new_dir = pwm_control_reg[`BPWM_CTRL_DIR];

  // Pending reversal inside the final prescaled instruction cycle
  wire dir_switch = pwm_on && act_full && pwm_control_reg[`BPWM_CTRL_FULL] &&
                    (new_dir != act_dir) && tb_run && tb_last_step;
  wire steer_dir = dir_switch ? new_dir : act_dir;

  // Dead-band stage: one counter per half-bridge leg
  wire [8:0] db_cycles = {act_deadband, 2'b00};
  wire [1:0] leg_raw = {!pwm_raw, pwm_raw};
  wire [1:0] leg_out;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_leg
      reg [8:0] on_cnt;
      // Counts pclk since the leg went active; clears at once on inactive
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          on_cnt <= 9'h000;
        else if (ce) begin
          if (!leg_raw[gi] || !tb_run)
            on_cnt <= 9'h000;
          else if (on_cnt != `BPWM_DB_CNT_MAX)
            on_cnt <= on_cnt + 9'h001;
        end
      end
      // Rising delayed, falling immediate; short pulses vanish entirely
      assign leg_out[gi] = leg_raw[gi] && tb_run && (on_cnt >= db_cycles);
    end
  endgenerate

  // Steering to active-true levels and pin ownership
  reg [3:0] next_level;
  reg [3:0] next_en;
  always @* begin
    next_level = 4'h0;
    next_en = 4'h0;
    if (pwm_on) begin
      case (act_cfg)
        `BPWM_CFG_SINGLE: begin
          next_en = 4'h1;
          next_level[0] = pwm_raw;
        end
        `BPWM_CFG_HALF: begin
          next_en = 4'h3;
          next_level[0] = leg_out[0];
          next_level[1] = leg_out[1];
        end
        default: begin
          next_en = 4'hF;
          if (!steer_dir) begin
            next_level[0] = 1'b1;
            next_level[3] = pwm_raw && !dir_switch;
          end else begin
            next_level[2] = 1'b1;
            next_level[1] = pwm_raw && !dir_switch;
          end
        end
      endcase
    end
  end

  // Per-pair polarity applied after steering and dead-band
  wire pol_ac = act_ctrl[`BPWM_CTRL_POL_AC];
  wire pol_bd = act_ctrl[`BPWM_CTRL_POL_BD];
  wire [3:0] pol_mask = {pol_bd, pol_ac, pol_bd, pol_ac};
  wire [3:0] next_pins = (next_level ^ pol_mask) & next_en;

  // Registered pins; released pins drive low with enable off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
      out_d <= 1'b0;
      out_a_en <= 1'b0;
      out_b_en <= 1'b0;
      out_c_en <= 1'b0;
      out_d_en <= 1'b0;
    end else if (ce) begin
      out_a <= next_pins[0];
      out_b <= next_pins[1];
      out_c <= next_pins[2];
      out_d <= next_pins[3];
      out_a_en <= next_en[0];
      out_b_en <= next_en[1];
      out_c_en <= next_en[2];
      out_d_en <= next_en[3];
    end
  end

endmodule // bpwm_steer

// ### test/bpwm_steer_monitor.sv
// Assertions on the APB and pin ports of the steering block
`timescale 1ns/100ps
module bpwm_steer_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire out_a,
  input wire out_b,
  input wire out_c,
  input wire out_d,
  input wire out_a_en,
  input wire out_b_en,
  input wire out_c_en,
  input wire out_d_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus answer timing and error response
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  access_phase_a: assert property (pready |-> $past(psel && penable))
    else $error("answer outside access");
  setup_phase_a: assert property (pready |-> $past(psel, 2) && !$past(penable, 2))
    else $error("answer without setup");
  err_decode_a: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("error response wrong for address");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("error read not zero");
  // Pins handed back to port use
  released_low_a: assert property (
    !((out_a && !out_a_en) || (out_b && !out_b_en) || (out_c && !out_c_en) || (out_d && !out_d_en)))
    else $error("released pin driven");
  enable_set_a: assert property (
    {out_d_en, out_c_en, out_b_en, out_a_en} inside {4'h0, 4'h1, 4'h3, 4'hF})
    else $error("illegal pin ownership");
endmodule // bpwm_steer_monitor

bind bpwm_steer bpwm_steer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_a_en(out_a_en),
  .out_b_en(out_b_en), .out_c_en(out_c_en), .out_d_en(out_d_en));

// ### test/bpwm_switch_model.sv
// Behavioural model of the external bridge switch drivers
`timescale 1ns/100ps
module bpwm_switch_model (
  input wire pclk,
  input wire [3:0] pin,
  input wire [3:0] pin_en,
  input wire pol_ac,
  input wire pol_bd,
  output logic shoot
);
  logic [3:0] on;
  // A switch conducts only on an owned pin at its active level
  assign on = pin_en & (pin ^ {pol_bd, pol_ac, pol_bd, pol_ac});
  // Legs are a over b and c over d; both on shorts the supply
  always @(posedge pclk) begin
    shoot <= (on[0] && on[1]) || (on[2] && on[3]);
  end
endmodule // bpwm_switch_model

// ### test/bridge_pwm_output_steering_tb.sv
// Self-checking bench for the bridge PWM output steering block
`timescale 1ns/100ps
module bridge_pwm_output_steering_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, shoot, err, pol_ac, pol_bd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic out_a, out_b, out_c, out_d, out_a_en, out_b_en, out_c_en, out_d_en;
  logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [7:0] rsts [5] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
  int mismatches, n_checks, act[4], tog, sw, sh, dt, p;
  bpwm_steer DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
    .out_a_en(out_a_en), .out_b_en(out_b_en), .out_c_en(out_c_en), .out_d_en(out_d_en));
  bpwm_switch_model drivers (.pclk(pclk), .pin({out_d, out_c, out_b, out_a}),
    .pin_en({out_d_en, out_c_en, out_b_en, out_a_en}), .pol_ac(pol_ac), .pol_bd(pol_bd),
    .shoot(shoot));
  // Clock and hang guard
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  task automatic report_and_stop;
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic int pre(input int ps);
    return ps == 0 ? 1 : ps == 1 ? 4 : 16;
  endfunction
  function automatic int clip(input int v);
    return v < 0 ? 0 : v;
  endfunction
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    // Look at the settled answer mid-cycle, then release after the sampling edge
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  // Programs a configuration and lets three periods pass so shadows load
  task automatic cfg(input logic [1:0] c, input logic [3:0] m, input logic [9:0] d,
                     input int ps, input int db);
    apb(1, 8'h0C, 32'(db));
    apb(1, 8'h08, 32'h3);
    apb(1, 8'h04, {24'h0, d[9:2]});
    apb(1, 8'h10, 32'h4 | 32'(ps));
    apb(1, 8'h00, {24'h0, c, d[1:0], m});
    pol_ac = m[1];
    pol_bd = m[0];
    repeat (48 * pre(ps)) @(posedge pclk);
  endtask
  // Counts active cycles per pin, toggles of out_a, switch gaps and shorts
  task automatic meas(input int n);
    logic [3:0] on;
    logic last;
    act = '{0, 0, 0, 0};
    tog = 0;
    sw = 0;
    #1;
    last = out_a ^ pol_ac;
    repeat (n) begin
      @(posedge pclk);
      #1;
      on = {out_d ^ pol_bd, out_c ^ pol_ac, out_b ^ pol_bd, out_a ^ pol_ac};
      foreach (act[i]) act[i] += on[i];
      tog += int'(on[0] != last);
      last = on[0];
      sw += int'(on == 4'h4);
      sh += int'(shoot === 1'b1);
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, pol_ac, pol_bd} = '0;
    {mismatches, n_checks, sh} = '0;
    void'($urandom(87890));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    foreach (offs[i]) begin
      apb(0, offs[i], 0);
      chk("reset value", rd, {24'h0, rsts[i]});
    end
    apb(1, 8'h18, 32'h5A);
    chk("unmapped error", err, 1);
    apb(1, 8'h0C, 32'hFF);
    apb(0, 8'h0C, 0);
    chk("deadband count", rd, 32'h7F);
    for (int ps = 0; ps < 3; ps++) begin
      dt = 1 + $urandom % 15;
      p = pre(ps);
      cfg(2'h0, 4'hC | 4'($urandom % 4), 10'(dt), ps, 0);
      meas(48 * p);
      chk("single active", act[0], 3 * dt * p);
      chk("single toggles", tog, 6);
      chk("single pins", {out_d_en, out_c_en, out_b_en, out_a_en}, 4'h1);
    end
    for (int db = 0; db < 4; db++) begin
      dt = 1 + $urandom % 15;
      cfg(2'h2, 4'hC | 4'($urandom % 4), 10'(dt), 0, db);
      meas(48);
      chk("half leg a", act[0], 3 * clip(dt - 4 * db));
      chk("half leg b", act[1], 3 * clip(16 - dt - 4 * db));
      chk("half pins", {out_d_en, out_c_en, out_b_en, out_a_en}, 4'h3);
    end
    for (int r = 0; r < 2; r++) begin
      cfg(r ? 2'h3 : 2'h1, 4'hC, 10'd10, 1, 5);
      meas(192);
      chk("held pin", act[r * 2], 192);
      chk("modulated pin", act[3 - r * 2], 120);
      chk("idle pins", act[1 - r] + act[2 + r], 0);
    end
    cfg(2'h1, 4'hC, 10'h3FF, 1, 0);
    do apb(0, 8'h14, 0); while (rd[7:0] !== 8'h1);
    repeat ($urandom % 4) @(posedge pclk);
    apb(1, 8'h00, 32'hFC);
    meas(192);
    chk("switch interval", sw, 16);
    chk("leg overlap", sh, 0);
    report_and_stop;
  end
endmodule // bridge_pwm_output_steering_tb
